// >>> tb/olss_strobe_model.sv
// Strobe light model that sits on the output line of the source select block.
// It assumes the line is sampled on clk_i and that an inactive enable means the
// line is left open, so the light never fires.
`timescale 1ns/10ps

module olss_strobe_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        line_i,
  input  wire logic        oe_i,
  output logic      [15:0] pulse_count_o,
  output logic      [15:0] last_width_o
);
  logic        prev;
  logic        act;
  logic [15:0] run;

  // Light only fires while the line is driven and active
  assign act = line_i & oe_i;

  // Count flashes and measure each flash length in clock cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev          <= 1'b0;
      run           <= 16'h0000;
      pulse_count_o <= 16'h0000;
      last_width_o  <= 16'h0000;
    end else begin
      prev <= act;
      if (act) begin
        run <= prev ? run + 16'h0001 : 16'h0001;
      end
      if (act && !prev) begin
        pulse_count_o <= pulse_count_o + 16'h0001;
      end
      if (!act && prev) begin
        last_width_o <= run;
      end
    end
  end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench of the output line source select block.
// It assumes the reset register values and a 40 MHz clock, 40 cycles a microsecond.
`timescale 1ns/10ps
`include "olss_defs.svh"

module tb_top;
  import olss_pkg::*;

  typedef struct {
    logic [4:0]  src;
    logic [11:0] evt;
    logic [5:0]  lvl;
    logic        exp_hi;
  } olss_tb_row_t;

  logic             clk;
  logic             rst;
  logic             wb_cyc;
  logic             wb_stb;
  logic             wb_we;
  logic [7:0]       wb_adr;
  logic [31:0]      wb_dat_w;
  logic [31:0]      wb_dat_r;
  logic             wb_ack;
  olss_evt_t        evt;
  olss_lvl_t        lvl;
  logic             line;
  logic             line_oe;
  logic [15:0]      pulses;
  logic [15:0]      width;
  int               bad_count;
  int               n_checks;
  logic [31:0]      rd;
  logic [15:0]      c0;
  int               n;
  olss_tb_row_t     rows [17];

  olss_top dut_u (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
    .wb_ack_o(wb_ack), .evt_i(evt), .lvl_i(lvl), .line_o(line), .line_oe_o(line_oe)
  );

  olss_strobe_model lamp_u (
    .clk_i(clk), .rst_i(rst), .line_i(line), .oe_i(line_oe),
    .pulse_count_o(pulses), .last_width_o(width)
  );

  // ****************
  // Helper tasks
  // ****************
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Classic single cycle; the request holds until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= a;
    wb_dat_w <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (wb_ack === 1'b1) break;
    end
    if (k == 20) begin
      bad_count++;
      final_report();
    end
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  // One event cycle on the chosen source
  task automatic fire(input logic [11:0] m);
    evt <= m;
    cycles(1);
    evt <= 12'h000;
  endtask

  // ****************
  // Clock and stimulus
  // ****************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_dat_w = 32'h0000_0000;
    evt = '0;
    lvl = '0;
    bad_count = 0;
    n_checks = 0;
    // Pulse options in select order, the four plain levels, then off with all levels up
    for (int i = 0; i < 12; i++) begin
      rows[i] = '{src: 5'(i + 1), evt: 12'h800 >> i, lvl: 6'h00, exp_hi: 1'b1};
    end
    for (int i = 0; i < 4; i++) begin
      rows[12 + i] = '{src: 5'(14 + i), evt: 12'h000, lvl: 6'h20 >> i, exp_hi: 1'b1};
    end
    rows[16] = '{src: 5'h00, evt: 12'h000, lvl: 6'h3F, exp_hi: 1'b0};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    cycles(1);

    // Reset values and an unmapped read
    check(line_oe, 1'b0);
    wb_xfer(1'b0, `OLSS_ADR_CTRL, 32'h0);
    check(rd, 32'h0000_0000);
    wb_xfer(1'b0, `OLSS_ADR_STATUS, 32'h0);
    check(rd, 32'h0000_0000);
    wb_xfer(1'b0, `OLSS_ADR_LINES, 32'h0);
    check(rd, 32'h0000_0001);
    wb_xfer(1'b0, `OLSS_ADR_WIDTH, 32'h0);
    check(rd, 32'h0000_0001);
    wb_xfer(1'b0, `OLSS_ADR_DELAY, 32'h0);
    check(rd, 32'h0000_0000);
    wb_xfer(1'b0, 8'h18, 32'h0);
    check(rd, 32'h0000_0000);
    $display("test reset done");

    // Table of sources: one pulse of one microsecond, or a followed level
    for (int i = 0; i < 17; i++) begin
      wb_xfer(1'b1, `OLSS_ADR_CTRL, 32'h0000_0200 | rows[i].src);
      c0 = pulses;
      if (rows[i].lvl != 6'h00) begin
        lvl <= rows[i].lvl;
        cycles(3);
        check(line, rows[i].exp_hi);
        lvl <= 6'h00;
        cycles(3);
        check(line, 1'b0);
      end else begin
        fire(rows[i].evt);
        cycles(50);
        check(pulses - c0, {15'h0000, rows[i].exp_hi});
        check(width, 16'd40);
      end
    end
    $display("test source table done");

    // Host command write fires the pulse
    wb_xfer(1'b1, `OLSS_ADR_CTRL, 32'h0000_020D);
    c0 = pulses;
    wb_xfer(1'b1, `OLSS_ADR_CMD, 32'h0000_0001);
    cycles(50);
    check(pulses - c0, 16'h0001);
    $display("test host command done");

    // Falling activation ignores the rise and fires on the fall
    wb_xfer(1'b1, `OLSS_ADR_CTRL, 32'h0000_0301);
    c0 = pulses;
    evt <= 12'h800;
    cycles(50);
    check(pulses - c0, 16'h0000);
    evt <= 12'h000;
    cycles(50);
    check(pulses - c0, 16'h0001);
    $display("test falling edge done");

    // A second event inside an active pulse neither adds nor stretches
    wb_xfer(1'b1, `OLSS_ADR_CTRL, 32'h0000_0201);
    c0 = pulses;
    fire(12'h800);
    cycles(10);
    fire(12'h800);
    cycles(60);
    check(pulses - c0, 16'h0001);
    check(width, 16'd40);
    $display("test busy event done");

    // One microsecond delay then two microseconds wide
    wb_xfer(1'b1, `OLSS_ADR_DELAY, 32'h0000_0001);
    wb_xfer(1'b1, `OLSS_ADR_WIDTH, 32'h0000_0002);
    evt <= 12'h800;
    n = 0;
    for (int k = 0; k < 100; k++) begin
      @(posedge clk);
      evt <= 12'h000;
      n++;
      #1;
      if (line === 1'b1) break;
    end
    check(n, 42);
    // Status while the pulse stands: line high and generator busy
    wb_xfer(1'b0, `OLSS_ADR_STATUS, 32'h0);
    check(rd, 32'h0000_0003);
    cycles(100);
    check(width, 16'd80);
    wb_xfer(1'b1, `OLSS_ADR_DELAY, 32'h0000_0000);
    wb_xfer(1'b1, `OLSS_ADR_WIDTH, 32'h0000_0001);
    $display("test delay and width done");

    // Direction input leaves the line undriven
    wb_xfer(1'b1, `OLSS_ADR_CTRL, 32'h0000_0001);
    c0 = pulses;
    fire(12'h800);
    cycles(50);
    check(line_oe, 1'b0);
    check(pulses - c0, 16'h0000);
    // Control keeps only its defined bits; code 31 acts as off
    wb_xfer(1'b1, `OLSS_ADR_CTRL, 32'hFFFF_FFFF);
    wb_xfer(1'b0, `OLSS_ADR_CTRL, 32'h0);
    check(rd, 32'h0000_031F);
    check(line_oe, 1'b1);
    check(line, 1'b0);
    $display("test direction done");

    // Smart strobe needs more than one line per trigger
    wb_xfer(1'b1, `OLSS_ADR_CTRL, 32'h0000_0212);
    lvl <= 6'h02;
    cycles(3);
    check(line, 1'b0);
    wb_xfer(1'b1, `OLSS_ADR_LINES, 32'h0000_0002);
    cycles(3);
    check(line, 1'b1);
    lvl <= 6'h01;
    cycles(3);
    check(line, 1'b1);
    lvl <= 6'h00;
    cycles(3);
    check(line, 1'b0);
    $display("test smart strobe done");

    // Reset in mid-pulse drops the line and restores the registers
    wb_xfer(1'b1, `OLSS_ADR_CTRL, 32'h0000_0201);
    fire(12'h800);
    cycles(5);
    check(line, 1'b1);
    rst <= 1'b1;
    cycles(2);
    check(line, 1'b0);
    check(line_oe, 1'b0);
    rst <= 1'b0;
    cycles(1);
    wb_xfer(1'b0, `OLSS_ADR_CTRL, 32'h0);
    check(rd, 32'h0000_0000);
    wb_xfer(1'b0, `OLSS_ADR_LINES, 32'h0);
    check(rd, 32'h0000_0001);
    $display("test mid-run reset done");

    final_report();
  end
endmodule

// >>> verilog/olss_defs.svh
// Constants of the output line source select block: register offsets,
// field positions, reset values and timing counts.
// Assumes a 40 MHz system clock and a 32-bit classic Wishbone bus.
`ifndef OLSS_DEFS_SVH
`define OLSS_DEFS_SVH

// Register byte offsets
`define OLSS_ADR_CTRL       8'h00
`define OLSS_ADR_LINES      8'h04
`define OLSS_ADR_DELAY      8'h08
`define OLSS_ADR_WIDTH      8'h0C
`define OLSS_ADR_CMD        8'h10
`define OLSS_ADR_STATUS     8'h14

// Control register fields
`define OLSS_CTRL_SRC_LSB   0
`define OLSS_CTRL_SRC_W     5
`define OLSS_CTRL_EDGE_BIT  8
`define OLSS_CTRL_DIR_BIT   9

// Reset values
`define OLSS_RST_CTRL       32'h0000_0000
`define OLSS_RST_LINES      16'h0001
`define OLSS_RST_DELAY      16'h0000
`define OLSS_RST_WIDTH      16'h0001

// Timing: microsecond base against the clock period
`define OLSS_US_NS          1000
`define OLSS_CLK_PERIOD_NS  25
`define OLSS_CYC_PER_US     ((`OLSS_US_NS) / (`OLSS_CLK_PERIOD_NS))

`endif

// >>> verilog/olss_pkg.sv
// Types of the output line source select block.
// Assumes olss_defs.svh for all numeric constants.
package olss_pkg;

  // Output source choices, register field order
  typedef enum logic [4:0] {
    OLSS_SRC_OFF,
    OLSS_SRC_PULSE_AT_EXPOSURE_FINISH,
    OLSS_SRC_PULSE_AT_READOUT_BEGIN,
    OLSS_SRC_PULSE_AT_READOUT_FINISH,
    OLSS_SRC_PULSE_AT_ACCEPTED_TRIGGER,
    OLSS_SRC_PULSE_AT_REJECTED_TRIGGER,
    OLSS_SRC_PULSE_AT_ACQUISITION_BEGIN,
    OLSS_SRC_PULSE_AT_ACQUISITION_FINISH,
    OLSS_SRC_PULSE_AT_TIMER_ONE_EXPIRY,
    OLSS_SRC_PULSE_AT_COUNTER_ONE_EXPIRY,
    OLSS_SRC_PULSE_AT_INPUT_ONE_EVENT,
    OLSS_SRC_PULSE_AT_INPUT_TWO_EVENT,
    OLSS_SRC_PULSE_AT_ENCODER_EVENT,
    OLSS_SRC_PULSE_AT_HOST_COMMAND,
    OLSS_SRC_FRAME_TRIGGER_LEVEL,
    OLSS_SRC_FRAME_VALID_LEVEL,
    OLSS_SRC_EXPOSURE_LEVEL,
    OLSS_SRC_LINE_VALID_LEVEL,
    OLSS_SRC_READOUT_OR_DELAY_STROBE
  } olss_src_t;

  // Internal event signals that can fire a pulse
  typedef struct packed {
    logic exposure_finish;
    logic readout_begin;
    logic readout_finish;
    logic accepted_trigger;
    logic rejected_trigger;
    logic acquisition_begin;
    logic acquisition_finish;
    logic timer_one_expiry;
    logic counter_one_expiry;
    logic input_one_event;
    logic input_two_event;
    logic encoder_event;
  } olss_evt_t;

  // Internal activity levels
  typedef struct packed {
    logic frame_trigger;
    logic frame_valid;
    logic exposure;
    logic line_valid;
    logic readout;
    logic exposure_delay;
  } olss_lvl_t;

  // Pulse generator states
  typedef enum logic [1:0] {
    OLSS_ST_IDLE,
    OLSS_ST_DELAY,
    OLSS_ST_ACTIVE
  } olss_state_t;

endpackage

// >>> verilog/olss_top.sv
// Output line source select: routes one internal event (as a timed pulse)
// or one internal activity level onto a general-purpose output line.
// Assumes event and level inputs come from logic on clk_i, and software
// configures it over a 32-bit classic Wishbone slave.
//
// Operation
// - exposure-finish option pulses the line once per finished exposure.
// - readout-begin or readout-finish option pulses once per sensor readout.
// - accepted or rejected trigger option pulses once per such line trigger.
// - acquisition begin or finish option pulses when acquisition starts or stops.
// - timer-one or counter-one option pulses when that unit reaches its end.
// - input-one or input-two option pulses once per event on that input.
// - encoder option pulses once per encoder event.
// - host-command option pulses once per host command write.
// - frame-trigger option drives the line exactly while frame trigger is active; the registered line here lags it by one clock.
// - frame-valid option drives the line while a frame is in progress.
// - exposure option drives the line during each exposure, low otherwise.
// - line-valid option drives the line while line valid is asserted.
// - smart strobe drives the line during readout or exposure delay.
// - smart strobe works only when lines per trigger exceeds one.
// - edge setting chooses which source transition launches the pulse.
// - rising setting launches only on a low-to-high source transition.
// - falling setting launches only on a high-to-low source transition.
// - nothing is driven unless the line direction is output.
// - each pulse starts after a programmed delay in microseconds.
// - each pulse lasts a programmed width in microseconds.
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "olss_defs.svh"

module olss_top (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire olss_pkg::olss_evt_t evt_i,
  input  wire olss_pkg::olss_lvl_t lvl_i,
  output logic                   line_o,
  output logic                   line_oe_o
);
  import olss_pkg::*;

  localparam int unsigned CYC_US = `OLSS_CYC_PER_US;
  localparam logic [5:0]  CYC_LAST = 6'(CYC_US - 1);

  // ************************************************************
  // Register file
  // ************************************************************
  logic [31:0] ctrl;
  logic [15:0] lines_per_trigger;
  logic [15:0] pulse_start_delay;
  logic [15:0] pulse_width_setting;
  logic        host_cmd;
  olss_src_t   output_source_select;
  logic        pulse_edge_select;      // 0 edge_low_to_high, 1 edge_high_to_low
  logic        line_direction;         // 1 output
  logic        wb_req;
  logic        wb_wr;

  assign output_source_select = olss_src_t'(ctrl[`OLSS_CTRL_SRC_LSB +: `OLSS_CTRL_SRC_W]);
  assign pulse_edge_select    = ctrl[`OLSS_CTRL_EDGE_BIT];
  assign line_direction       = ctrl[`OLSS_CTRL_DIR_BIT];
  assign wb_req               = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr                = wb_req && wb_we_i;

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Configuration writes; unmapped offsets are ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl                <= `OLSS_RST_CTRL;
      lines_per_trigger   <= `OLSS_RST_LINES;
      pulse_start_delay   <= `OLSS_RST_DELAY;
      pulse_width_setting <= `OLSS_RST_WIDTH;
    end else if (wb_wr) begin
      unique case (wb_adr_i)
        `OLSS_ADR_CTRL:  ctrl <= lane_merge(ctrl, wb_dat_i, wb_sel_i) & 32'h0000_031F;
        `OLSS_ADR_LINES: lines_per_trigger <=
                           16'(lane_merge({16'h0000, lines_per_trigger}, wb_dat_i, wb_sel_i));
        `OLSS_ADR_DELAY: pulse_start_delay <=
                           16'(lane_merge({16'h0000, pulse_start_delay}, wb_dat_i, wb_sel_i));
        `OLSS_ADR_WIDTH: pulse_width_setting <=
                           16'(lane_merge({16'h0000, pulse_width_setting}, wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_cmd <= 1'b0;
    end else begin
      host_cmd <= wb_wr && (wb_adr_i == `OLSS_ADR_CMD) && wb_sel_i[0] && wb_dat_i[0];
    end
  end

  // ************************************************************
  // Source selection and edge qualification
  // ************************************************************
  logic        src_level;    // selected source, pulse options
  logic        src_prev;
  logic        is_pulse_src;
  logic        lvl_out;      // level options output value
  logic        strobe_ok;
  logic        launch_edge;
  logic        launch;
  olss_state_t st;

  // smart strobe gated on lines per trigger
  assign strobe_ok = (lines_per_trigger > 16'h0001);

  always_comb begin
    src_level    = 1'b0;
    lvl_out      = 1'b0;
    // Codes from the first to the last pulse option launch timed pulses
    is_pulse_src = (output_source_select >= OLSS_SRC_PULSE_AT_EXPOSURE_FINISH) &&
                   (output_source_select <= OLSS_SRC_PULSE_AT_HOST_COMMAND);
    unique case (output_source_select)
      OLSS_SRC_PULSE_AT_EXPOSURE_FINISH:    src_level = evt_i.exposure_finish;
      OLSS_SRC_PULSE_AT_READOUT_BEGIN:      src_level = evt_i.readout_begin;
      OLSS_SRC_PULSE_AT_READOUT_FINISH:     src_level = evt_i.readout_finish;
      OLSS_SRC_PULSE_AT_ACCEPTED_TRIGGER:   src_level = evt_i.accepted_trigger;
      OLSS_SRC_PULSE_AT_REJECTED_TRIGGER:   src_level = evt_i.rejected_trigger;
      OLSS_SRC_PULSE_AT_ACQUISITION_BEGIN:  src_level = evt_i.acquisition_begin;
      OLSS_SRC_PULSE_AT_ACQUISITION_FINISH: src_level = evt_i.acquisition_finish;
      OLSS_SRC_PULSE_AT_TIMER_ONE_EXPIRY:   src_level = evt_i.timer_one_expiry;
      OLSS_SRC_PULSE_AT_COUNTER_ONE_EXPIRY: src_level = evt_i.counter_one_expiry;
      OLSS_SRC_PULSE_AT_INPUT_ONE_EVENT:    src_level = evt_i.input_one_event;
      OLSS_SRC_PULSE_AT_INPUT_TWO_EVENT:    src_level = evt_i.input_two_event;
      OLSS_SRC_PULSE_AT_ENCODER_EVENT:      src_level = evt_i.encoder_event;
      OLSS_SRC_PULSE_AT_HOST_COMMAND:       src_level = host_cmd;
      OLSS_SRC_FRAME_TRIGGER_LEVEL:         lvl_out = lvl_i.frame_trigger;
      OLSS_SRC_FRAME_VALID_LEVEL:           lvl_out = lvl_i.frame_valid;
      OLSS_SRC_EXPOSURE_LEVEL:              lvl_out = lvl_i.exposure;
      OLSS_SRC_LINE_VALID_LEVEL:            lvl_out = lvl_i.line_valid;
      OLSS_SRC_READOUT_OR_DELAY_STROBE:
        lvl_out = strobe_ok && (lvl_i.readout || lvl_i.exposure_delay);
      // Off and unused codes select no source, so the line is driven low
      default: ;
    endcase
  end

  // Previous source value for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_level;
    end
  end

  assign launch_edge = pulse_edge_select ? (src_prev && !src_level)
                                         : (!src_prev && src_level);
  // only an idle generator accepts a launch
  assign launch = line_direction && is_pulse_src && launch_edge && (st == OLSS_ST_IDLE);

  // ************************************************************
  // Pulse generator, microsecond timed
  // ************************************************************
  logic [5:0]  cyc_cnt;
  logic [15:0] us_cnt;
  logic [15:0] width_eff;
  logic        us_tick;

  // A zero width would wrap the 16-bit microsecond count and give a very long pulse, so it counts as one
  assign width_eff = (pulse_width_setting == 16'h0000) ? 16'h0001 : pulse_width_setting;
  assign us_tick   = (cyc_cnt == CYC_LAST);

  // Cycle prescaler restarts at each launch so timing is exact
  always_ff @(posedge clk_i) begin
    if (rst_i || launch || us_tick) begin
      cyc_cnt <= 6'h00;
    end else if (st != OLSS_ST_IDLE) begin
      cyc_cnt <= cyc_cnt + 6'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !line_direction) begin
      st     <= OLSS_ST_IDLE;
      us_cnt <= 16'h0000;
    end else begin
      unique case (st)
        OLSS_ST_IDLE: begin
          if (launch) begin
            if (pulse_start_delay == 16'h0000) begin
              st     <= OLSS_ST_ACTIVE;
              us_cnt <= width_eff;
            end else begin
              st     <= OLSS_ST_DELAY;
              us_cnt <= pulse_start_delay;
            end
          end
        end
        OLSS_ST_DELAY: begin
          if (us_tick) begin
            if (us_cnt == 16'h0001) begin
              st     <= OLSS_ST_ACTIVE;
              us_cnt <= width_eff;
            end else begin
              us_cnt <= us_cnt - 16'h0001;
            end
          end
        end
        OLSS_ST_ACTIVE: begin
          if (us_tick) begin
            if (us_cnt == 16'h0001) begin
              st <= OLSS_ST_IDLE;
            end else begin
              us_cnt <= us_cnt - 16'h0001;
            end
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Line drive and status readback
  // ************************************************************
  logic next_line;

  // drive only when direction is output
  assign next_line = line_direction &&
                     (is_pulse_src ? (st == OLSS_ST_ACTIVE) : lvl_out);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_o    <= 1'b0;
      line_oe_o <= 1'b0;
    end else begin
      line_o    <= next_line;
      line_oe_o <= line_direction;
    end
  end

  // Read data is registered alongside ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        `OLSS_ADR_CTRL:   wb_dat_o <= ctrl;
        `OLSS_ADR_LINES:  wb_dat_o <= {16'h0000, lines_per_trigger};
        `OLSS_ADR_DELAY:  wb_dat_o <= {16'h0000, pulse_start_delay};
        `OLSS_ADR_WIDTH:  wb_dat_o <= {16'h0000, pulse_width_setting};
        `OLSS_ADR_STATUS: wb_dat_o <= {29'h0000_0000, src_level,
                                       (st != OLSS_ST_IDLE), line_o};
        default:          wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  logic [21:0] hi_len;

  // Cycles the line has been high in a pulse
  always_ff @(posedge clk_i) begin
    if (rst_i || !line_o) begin
      hi_len <= 22'h00_0000;
    end else begin
      hi_len <= hi_len + 22'h00_0001;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_follows: assert property (wb_req |=> wb_ack_o)
    else $error("request not acked next cycle");
  chk_input_quiet: assert property (!line_direction |=> !line_o && !line_oe_o)
    else $error("line driven while direction is input");
  chk_rise_launch: assert property (
    (!pulse_edge_select && line_direction && is_pulse_src && st == OLSS_ST_IDLE
     && !src_prev && src_level) |=> st != OLSS_ST_IDLE)
    else $error("rising edge did not launch pulse");
  chk_fall_launch: assert property (
    (pulse_edge_select && st == OLSS_ST_IDLE && !src_prev && src_level) |=> st == OLSS_ST_IDLE)
    else $error("rising edge launched under falling setting");
  chk_no_restart: assert property (
    (st == OLSS_ST_ACTIVE && launch_edge) |=> (st == OLSS_ST_IDLE || us_cnt <= $past(us_cnt)))
    else $error("active pulse restarted by new event");
  chk_exposure_level: assert property (
    (line_direction && output_source_select == OLSS_SRC_EXPOSURE_LEVEL)
    |=> line_o == $past(lvl_i.exposure))
    else $error("exposure level not followed");
  chk_strobe_gate: assert property (
    (output_source_select == OLSS_SRC_READOUT_OR_DELAY_STROBE && !strobe_ok) |=> !line_o)
    else $error("smart strobe active with one line per trigger");
  chk_pulse_width: assert property (
    (line_direction && is_pulse_src && line_o && !next_line && $stable(pulse_width_setting))
    |-> hi_len + 22'h00_0001 == 22'(width_eff * CYC_US))
    else $error("pulse width differs from setting");

  cov_pulse_done: cover property (st == OLSS_ST_ACTIVE ##1 st == OLSS_ST_IDLE);
  cov_delay_used: cover property (st == OLSS_ST_DELAY ##1 st == OLSS_ST_ACTIVE);
  cov_host_pulse: cover property (
    output_source_select == OLSS_SRC_PULSE_AT_HOST_COMMAND && launch);
  cov_strobe_on: cover property (
    output_source_select == OLSS_SRC_READOUT_OR_DELAY_STROBE && line_o);

endmodule
